// *** hdl/input_card_map.svh ***
// register offsets, field positions and reset values of the input card
`ifndef INPUT_CARD_MAP_SVH
`define INPUT_CARD_MAP_SVH
`define ADDR_CTRL 8'h00
`define ADDR_SLOT 8'h04
`define ADDR_DATA 8'h08
`define ADDR_STAT 8'h0c
`define CTRL_ISEL 0
`define CTRL_TIMING 1
`define CTRL_ARM 2
`define CTRL_LOOPBACK 3
`define CTRL_RESET 4'h8
`define SLOT_LSB 0
`define SLOT_MSB 3
`define SLOT_GATE 8
`define CARD_SLOT 4'h2
`define DATA_WIDTH 12
`define WORD_REQ 12
`define STAT_WAIT 0
`define STAT_REQ 1
`define STAT_SELECTED 2
`define STAT_FLAG 3
`define STAT_GATE 4
`endif

// *** hdl/input_card_pkg.sv ***
// types shared by the input card modules
package input_card_pkg;
	typedef enum logic [1:0] {st_idle, st_gate_wait, st_done} card_state_e;
	typedef logic [11:0] data_word_t;
	typedef logic [12:0] return_word_t;
	typedef logic [7:0] reg_addr_t;
	typedef logic [31:0] bus_word_t;
endpackage

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	// first stage feeds only the second stage
	always_comb
	begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule // pin_sync

// *** hdl/word_latch.sv ***
// holds the captured input word and its request flag
`timescale 1ns/10ps
`include "input_card_map.svh"
module word_latch (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic capture,
	input wire logic clear,
	input wire input_card_pkg::data_word_t data_in,
	output input_card_pkg::data_word_t data_held,
	output logic request
);
	import input_card_pkg::*;
	data_word_t next_data_held;
	logic next_request;

	// capture wins over clear so a landing word is never lost
	always_comb
	begin
		next_data_held = data_held;
		next_request = request;
		if (clear)
			next_request = 1'b0;
		if (capture)
		begin
			next_data_held = data_in;
			next_request = 1'b1;
		end
	end

	// word stays put between captures
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_held <= '0;
			request <= 1'b0;
		end
		else
		begin
			data_held <= next_data_held;
			request <= next_request;
		end
	end
endmodule // word_latch

// *** hdl/input_card.sv ***
// digital input card with gate/flag handshake behind a register port
// How it works
// - capture twelve input bits as return data
// - timing and arm both off: read completes without handshake
// - gate out, sample only after flag
// - flag latches data, ends backplane flag
// - many cards armed, only the last addressed slot answers
// - request flag sits above data bits
// - loopback ties gate to flag input
`timescale 1ns/10ps
`include "input_card_map.svh"
module input_card (
	input wire logic core_clk,
	input wire logic resetn,
	input wire input_card_pkg::reg_addr_t addr,
	input wire input_card_pkg::bus_word_t wdata,
	input wire logic wr,
	input wire logic rd,
	output input_card_pkg::bus_word_t rdata,
	input wire logic [11:0] data_pins,
	input wire logic ext_flag,
	output logic gate_out,
	output logic bp_flag
);
	import input_card_pkg::*;

	// control register and slot selection state
	logic [3:0] ctrl;
	logic [3:0] next_ctrl;
	logic selected;
	logic next_selected;

	// handshake sequencer state
	card_state_e state;
	card_state_e next_state;
	logic flag_prev;
	logic next_flag_prev;

	// pin outputs, registered so no decode glitch reaches the cable
	logic next_gate_out;
	logic next_bp_flag;

	// read port
	bus_word_t next_rdata;
	bus_word_t status;
	return_word_t ret_word;

	// synchronised pins
	data_word_t data_sync;
	logic ext_flag_sync;

	// flag source and its rising edge
	logic flag_src;
	logic flag_rise;

	// latch interface
	logic capture;
	logic clear;
	data_word_t data_held;
	logic request;

	// decoded bus accesses
	logic ctrl_write;
	logic slot_write;
	logic slot_match;
	logic gated;
	logic gated_hit;
	logic abort;

	// control fields and derived conditions
	logic isel;
	logic timing;
	logic armed;
	logic loopback;
	logic wait_mode;
	logic waiting;
	logic data_visible;

	// register offset compare, used for writes and reads
	function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
		hit = (a == target);
	endfunction

	// data pins, each bit synchronised on its own: the source must hold
	// its word steady while the flag stands, or a capture can tear
	pin_sync #(
		.WIDTH(`DATA_WIDTH)
	) data_sync_u (
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in(data_pins),
		.sync_out(data_sync)
	);

	// flag pin; only the second stage is ever read
	pin_sync #(
		.WIDTH(1)
	) flag_sync_u (
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in(ext_flag),
		.sync_out(ext_flag_sync)
	);

	// storage for the captured word and its request flag
	word_latch latch_u (
		.core_clk(core_clk),
		.resetn(resetn),
		.capture(capture),
		.clear(clear),
		.data_in(data_sync),
		.data_held(data_held),
		.request(request)
	);

	// field views of the control register
	assign isel = ctrl[`CTRL_ISEL];
	assign timing = ctrl[`CTRL_TIMING];
	assign armed = ctrl[`CTRL_ARM];
	assign loopback = ctrl[`CTRL_LOOPBACK];

	// arm behaves as timing mode: a gated address waits for the flag
	assign wait_mode = timing || armed;
	assign waiting = (state == st_gate_wait);
	// data word hidden until input is selected and this slot addressed
	assign data_visible = isel && selected;

	// return word: request flag sits just above the data bits
	assign ret_word = {request, data_held};

	// write decode
	assign ctrl_write = wr && hit(addr, `ADDR_CTRL);
	assign slot_write = wr && hit(addr, `ADDR_SLOT);
	assign slot_match = (wdata[`SLOT_MSB:`SLOT_LSB] == `CARD_SLOT);
	assign gated = wdata[`SLOT_GATE];
	// only a gated address to this slot starts a handshake or disarms the card
	assign gated_hit = slot_write && slot_match && gated;
	// a gated address with input deselected disarms the card
	assign abort = gated_hit && !isel;

	// flag source: own gate when no external timing circuit is fitted
	assign flag_src = loopback ? gate_out : ext_flag_sync;
	// edge only from the second sync stage or the gate flop
	assign flag_rise = flag_src && !flag_prev;

	// control register and slot selection: next values
	always_comb
	begin
		next_ctrl = ctrl;
		next_selected = selected;
		if (ctrl_write)
			next_ctrl = wdata[`CTRL_LOOPBACK:`CTRL_ISEL];
		if (slot_write)
			next_selected = slot_match;
	end

	// control register and slot selection: registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl <= `CTRL_RESET;
			selected <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			selected <= next_selected;
		end
	end

	// handshake sequencer: idle until a gated address, then either a
	// direct capture or a wait for the flag; done keeps the word, and
	// the next gated address clears only its request flag
	always_comb
	begin
		next_state = state;
		next_flag_prev = flag_src;
		capture = 1'b0;
		clear = 1'b0;
		unique case (state)
			st_idle, st_done:
			begin
				if (abort)
				begin
					clear = 1'b1;
					next_state = st_idle; // disarm, nothing captured
				end
				else if (gated_hit)
				begin
					clear = 1'b1;
					if (wait_mode)
						next_state = st_gate_wait;
					else
					begin
						capture = 1'b1;
						next_state = st_done;
					end
				end
			end
			st_gate_wait:
			begin
				// a landing flag beats a disarm in the same cycle
				if (flag_rise)
				begin
					capture = 1'b1;
					next_state = st_done;
				end
				else if (abort)
				begin
					clear = 1'b1;
					next_state = st_idle;
				end
			end
		endcase
	end

	// handshake sequencer: registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= st_idle;
			flag_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			flag_prev <= next_flag_prev;
		end
	end

	// pin outputs follow the next state so they come straight from flops
	always_comb
	begin
		next_gate_out = (next_state == st_gate_wait);
		// backplane flag held while waiting; its fall is the trailing edge
		next_bp_flag = (next_state == st_gate_wait);
	end

	// pin outputs: registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gate_out <= 1'b0;
			bp_flag <= 1'b0;
		end
		else
		begin
			gate_out <= next_gate_out;
			bp_flag <= next_bp_flag;
		end
	end

	// status word, a live view of the handshake for software polling
	always_comb
	begin
		status = '0;
		status[`STAT_WAIT] = waiting;
		status[`STAT_REQ] = request;
		status[`STAT_SELECTED] = selected;
		status[`STAT_FLAG] = bp_flag;
		status[`STAT_GATE] = gate_out;
	end

	// read data, one cycle after the strobe, zero elsewhere;
	// a zero idle value lets several cards share a wired-or bus
	always_comb
	begin
		next_rdata = '0;
		if (rd)
		begin
			if (hit(addr, `ADDR_CTRL))
				next_rdata[`CTRL_LOOPBACK:`CTRL_ISEL] = ctrl;
			else if (hit(addr, `ADDR_DATA))
			begin
				// plain read leaves the stored word untouched
				if (data_visible)
					next_rdata[`WORD_REQ:0] = ret_word;
			end
			else if (hit(addr, `ADDR_STAT))
				next_rdata = status;
		end
	end

	// read data: register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata <= '0;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end
endmodule // input_card

// *** test/ext_source.sv ***
// data source on the far side of the gate
`timescale 1ns/10ps
module ext_source (
	input wire logic core_clk,
	input wire logic gate_out,
	input wire logic slow,
	input wire logic [11:0] word,
	output logic ext_flag = 1'b0,
	output logic [11:0] data_pins = 12'h000
);
	int n = 0;
	// a slow source shows wrong pins until ready
	always @(posedge core_clk)
	begin
		n <= gate_out ? n + 1 : 0;
		ext_flag <= gate_out && (ext_flag || n == (slow ? 20 : 3));
		data_pins <= (gate_out && slow && !ext_flag && n != 20) ? ~word : word;
	end
endmodule // ext_source

// *** test/input_card_sva.sv ***
// port assertions for the input card
`timescale 1ns/10ps
`include "input_card_map.svh"
module input_card_sva (
	input wire logic core_clk,
	input wire logic resetn,
	input wire input_card_pkg::reg_addr_t addr,
	input wire input_card_pkg::bus_word_t wdata,
	input wire logic wr,
	input wire logic rd,
	input wire input_card_pkg::bus_word_t rdata,
	input wire logic gate_out,
	input wire logic bp_flag
);
	import input_card_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	a_rdata_quiet: assert property (!$past(rd) |-> rdata == 0)
		else $error("rdata without read");
	a_gate_busy: assert property (gate_out == bp_flag)
		else $error("gate and busy differ");
	a_gate_cause: assert property ($rose(gate_out) |-> $past(wr)
		&& $past(addr) == `ADDR_SLOT && $past(wdata[`SLOT_GATE]))
		else $error("gate without gated address");
	a_data_form: assert property ($past(rd) && $past(addr) == `ADDR_DATA
		|-> rdata[31:13] == 0)
		else $error("data word too wide");
	a_data_early: assert property ($past(rd) && $past(addr) == `ADDR_DATA
		&& $past(gate_out) |-> !rdata[12])
		else $error("request while waiting");
	a_stat_live: assert property ($past(rd) && $past(addr) == `ADDR_STAT
		|-> rdata[31:5] == 0 && rdata[4] == $past(gate_out) && rdata[3] == $past(bp_flag))
		else $error("status mismatch");
	a_slot_wo: assert property ($past(rd) && $past(addr) == `ADDR_SLOT
		|-> rdata == 0)
		else $error("slot readable");
	a_ctrl_bits: assert property ($past(rd) && $past(addr) == `ADDR_CTRL
		|-> rdata[31:4] == 0)
		else $error("control too wide");
endmodule // input_card_sva
bind input_card input_card_sva sva_u (.core_clk(core_clk), .resetn(resetn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_out(gate_out), .bp_flag(bp_flag));

// *** test/testbench.sv ***
// self-checking bench for the input card
`timescale 1ns/10ps
`include "input_card_map.svh"
module testbench;
	import input_card_pkg::*;
	logic core_clk = 0;
	logic resetn = 0;
	logic wr = 0;
	logic rd = 0;
	logic slow = 0;
	reg_addr_t addr = 0;
	bus_word_t wdata = 0;
	bus_word_t rdata;
	bus_word_t v;
	data_word_t word = 12'ha5c;
	data_word_t data_pins;
	logic ext_flag;
	logic gate_out;
	logic bp_flag;
	int bad_count = 0;
	int total_checks = 0;
	always #20 core_clk = ~core_clk;
	input_card dut_u (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .data_pins(data_pins), .ext_flag(ext_flag),
		.gate_out(gate_out), .bp_flag(bp_flag));
	ext_source src_u (.core_clk(core_clk), .gate_out(gate_out), .slow(slow), .word(word),
		.ext_flag(ext_flag), .data_pins(data_pins));
	task chk(string n, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// spare edge after a write so the strobe is never set twice at once
	task wrr(reg_addr_t a, bus_word_t d);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 0;
		@(posedge core_clk);
	endtask
	task rdr(reg_addr_t a, output bus_word_t d);
		rd <= 1;
		addr <= a;
		@(posedge core_clk);
		rd <= 0;
		#1 d = rdata;
		@(posedge core_clk);
	endtask
	task wait_done;
		for (int i = 0; i < 60 && bp_flag !== 0; i++)
			@(posedge core_clk);
		if (bp_flag !== 0)
		begin
			bad_count++;
			wrap_up;
		end
	endtask
	task auto_read;
		rdr(`ADDR_DATA, v);
		chk("unselected", v, 0);
		wrr(`ADDR_CTRL, 1);
		wrr(`ADDR_SLOT, 32'h102);
		chk("no gate", gate_out, 0);
		rdr(`ADDR_DATA, v);
		chk("auto", v, 32'h1a5c);
	endtask
	// early read only when slow, a prompt answer may already be in
	task gated(logic [3:0] c, logic s, data_word_t w);
		slow <= s;
		word <= w;
		wrr(`ADDR_CTRL, {28'h0, c});
		wr <= 1;
		addr <= `ADDR_SLOT;
		wdata <= 32'h102;
		@(posedge core_clk);
		wr <= 0;
		// loopback drops the gate after one cycle, so look right after launch
		#1 chk("gate", gate_out, 1);
		chk("busy", bp_flag, 1);
		@(posedge core_clk);
		if (s)
			rdr(`ADDR_STAT, v);
		if (s)
			chk("status", v, 32'h1d);
		if (s)
			rdr(`ADDR_DATA, v);
		if (s)
			chk("early", v[12], 0);
		wait_done;
		chk("released", gate_out, 0);
		rdr(`ADDR_DATA, v);
		chk("word", v, {19'h0, 1'b1, w});
	endtask
	task hold;
		word <= 12'h0f0;
		wrr(`ADDR_SLOT, 32'h002);
		repeat (3) @(posedge core_clk);
		rdr(`ADDR_DATA, v);
		chk("held", v, 32'h1f0f);
		wrr(`ADDR_CTRL, 0);
		wrr(`ADDR_SLOT, 32'h102);
		wrr(`ADDR_CTRL, 1);
		rdr(`ADDR_DATA, v);
		chk("disarmed", v[12], 0);
		wrr(`ADDR_SLOT, 32'h003);
		rdr(`ADDR_DATA, v);
		chk("other slot", v, 0);
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		rdr(`ADDR_CTRL, v);
		chk("ctrl", v, `CTRL_RESET);
		rdr(8'h10, v);
		chk("unmapped", v, 0);
		auto_read;
		gated(4'h3, 1, 12'h5a1);
		gated(4'h5, 0, 12'h3c6);
		gated(4'hb, 0, 12'hf0f);
		hold;
		wrap_up;
	end
endmodule // testbench
